// ===== logic/tcc_pkg.sv
package tcc_pkg;

  // ****************************************
  // Calibration memory word addresses
  // ****************************************
  localparam int unsigned WORD_W        = 4;
  localparam int unsigned CAL_WORDS     = 32;
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0]  ADDR_ROOM_REF = 5'h00; // Words 0..2
  localparam logic [4:0]  ADDR_G2       = 5'h04; // Words 4..6
  localparam logic [4:0]  ADDR_CGAIN    = 5'h07;
  localparam logic [4:0]  ADDR_G1       = 5'h08; // Words 8..10
  localparam logic [4:0]  ADDR_COFF_LO  = 5'h0B;
  localparam logic [4:0]  ADDR_G0       = 5'h0C; // Words 12..14
  localparam logic [4:0]  ADDR_COFF_HI  = 5'h0F;
  localparam logic [4:0]  ADDR_O2       = 5'h14; // Words 20..22
  localparam logic [4:0]  ADDR_O1       = 5'h18; // Words 24..26
  localparam logic [4:0]  ADDR_O0       = 5'h1C; // Words 28..30

  // ****************************************
  // Field positions inside word 7
  // ****************************************
  localparam int unsigned BIT_FIRST_AMP = 0;
  localparam int unsigned BIT_SECOND    = 1;
  localparam int unsigned BIT_THIRD     = 2;
  localparam int unsigned BIT_SWAP      = 3;

  // ****************************************
  // Arithmetic widths
  // ****************************************
  localparam int unsigned COEF_W   = 12;
  localparam int unsigned DAC_W    = 10;
  localparam int unsigned TEMP_W   = 10;
  localparam int unsigned FRAC_W   = 11;  // Fraction bits of reference and slopes
  localparam int unsigned COFF_W   = 7;
  localparam int unsigned ACC_W    = 40;  // Full-precision accumulator

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic              first_stage_amp;
    logic              second_stage_gain;
    logic              third_stage_gain;
    logic              input_swap;
    logic [COFF_W-1:0] coarse_offset_value;
  } tcc_coarse_t;

  typedef struct packed {
    logic [DAC_W-1:0] fine_gain_code;
    logic [DAC_W-1:0] fine_offset_code;
    logic             gain_fault;
    logic             offset_fault;
  } tcc_fine_t;

endpackage : tcc_pkg

// ===== logic/tcc_coeff_engine.sv
// Notes on behaviour
// - Fine gain = G0 + G1*(T-Tref) + G2*(T-Tref)^2.
// - Fine offset = O0 + O1*(T-Tref) + O2*(T-Tref)^2.
// - Gain polynomial uses 12-bit operands, result truncated to 10 bits.
// - Offset polynomial uses 12-bit operands, result truncated to 10 bits.
// - Gain result outside [0..1] raises the gain fault.
// - Offset result outside [0..1] raises the offset fault.
// - Reference in words 0..2, top bit zero, unsigned 11-bit fraction.
// - Gain zero-order term in words 12..14, 10 used bits, unsigned fraction.
// - Gain first-order term in words 8..10, signed, range -1..1.
// - Gain second-order term in words 4..6, signed, range -1..1.
// - Offset zero-order term in words 28..30, 10 used bits, unsigned.
// - Offset first-order term in words 24..26, signed, range -1..1.
// - Offset second-order term in words 20..22, signed, range -1..1.
// - Word 7 holds three coarse gain stage selectors.
// - Coarse offset is 7-bit code split over words 11 and 15.
// - Fine gain code drives a linear gain DAC, 0.448 to 0.99.
// - Fine offset code drives a linear offset DAC, 1.136 to 1.59.
// - Each word holds four data bits plus odd parity bit.
// - Input swap bit lives in word 7 and flips input polarity.
`timescale 1ns/100ps

module tcc_coeff_engine
  import tcc_pkg::*;
#(
  parameter int unsigned TEMP_BITS = tcc_pkg::TEMP_W
)
(
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // Calibration memory write and read-back port
  input  wire logic                      cal_wr,
  input  wire logic [tcc_pkg::ADDR_W-1:0] cal_addr,
  input  wire logic [tcc_pkg::WORD_W:0]  cal_wdata,
  output logic [tcc_pkg::WORD_W:0]       cal_rdata,
  output logic                           cal_parity_err,
  // Temperature converter result
  input  wire logic                      temp_valid,
  input  wire logic [TEMP_BITS-1:0]      temp_value,
  // Analog chain settings
  output tcc_pkg::tcc_coarse_t           coarse,
  output tcc_pkg::tcc_fine_t             fine,
  output logic                           fine_valid
);
  import tcc_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // At least one zero pad bit is needed below the code to align it
  if (TEMP_BITS < 1 || TEMP_BITS > FRAC_W - 1)
  begin : g_bad_temp
    $error("TEMP_BITS must lie in 1..10");
  end

  // ****************************************
  // Calibration memory, data plus parity
  // ****************************************
  logic [WORD_W:0] cal_mem [CAL_WORDS];

  // Word storage, cleared to zero data with odd parity
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CAL_WORDS; i++)
        cal_mem[i] <= {1'b1, {WORD_W{1'b0}}};
    end
    else if (cal_wr)
    begin
      cal_mem[cal_addr] <= cal_wdata;
    end
  end

  // Read back and parity check of addressed word
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cal_rdata      <= '0;
      cal_parity_err <= 1'b0;
    end
    else
    begin
      cal_rdata      <= cal_mem[cal_addr];
      cal_parity_err <= ~(^cal_mem[cal_addr]);
    end
  end

  // ****************************************
  // Coefficient assembly, low word first
  // ****************************************
  function automatic logic [COEF_W-1:0] word3(input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] a;
    a = base;
    word3 = {cal_mem[a + 5'h02][WORD_W-1:0], cal_mem[a + 5'h01][WORD_W-1:0],
             cal_mem[a][WORD_W-1:0]};
  endfunction : word3

  logic [COEF_W-1:0] room_temp_ref;
  logic [COEF_W-1:0] gain_coeff_zero;
  logic [COEF_W-1:0] gain_coeff_first;
  logic [COEF_W-1:0] gain_coeff_second;
  logic [COEF_W-1:0] offset_coeff_zero;
  logic [COEF_W-1:0] offset_coeff_first;
  logic [COEF_W-1:0] offset_coeff_second;

  assign room_temp_ref       = word3(ADDR_ROOM_REF);
  assign gain_coeff_zero     = word3(ADDR_G0);
  assign gain_coeff_first    = word3(ADDR_G1);
  assign gain_coeff_second   = word3(ADDR_G2);
  assign offset_coeff_zero   = word3(ADDR_O0);
  assign offset_coeff_first  = word3(ADDR_O1);
  assign offset_coeff_second = word3(ADDR_O2);

  // ****************************************
  // Coarse settings to the analog chain
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      coarse <= '0;
    end
    else
    begin
      coarse.first_stage_amp     <= cal_mem[ADDR_CGAIN][BIT_FIRST_AMP];
      coarse.second_stage_gain   <= cal_mem[ADDR_CGAIN][BIT_SECOND];
      coarse.third_stage_gain    <= cal_mem[ADDR_CGAIN][BIT_THIRD];
      coarse.input_swap          <= cal_mem[ADDR_CGAIN][BIT_SWAP];
      coarse.coarse_offset_value <= {cal_mem[ADDR_COFF_HI][COFF_W-WORD_W-1:0],
                                     cal_mem[ADDR_COFF_LO][WORD_W-1:0]};
    end
  end

  // ****************************************
  // Temperature capture and difference
  // ****************************************
  logic signed [COEF_W:0] diff;     // Fraction with FRAC_W bits
  logic                   calc_go;

  // Align temperature to 11-bit fraction, form signed difference
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      diff    <= '0;
      calc_go <= 1'b0;
    end
    else
    begin
      calc_go <= temp_valid;
      if (temp_valid)
        diff <= $signed({2'b00, temp_value, {(FRAC_W-TEMP_BITS){1'b0}}})
              - $signed({2'b00, room_temp_ref[FRAC_W-1:0]});
    end
  end

  // ****************************************
  // Polynomial evaluation, full precision
  // ****************************************
  // Scale: diff has 11 fraction bits, slopes have 11, square has 22.
  localparam int unsigned SQ_FRAC  = 2 * FRAC_W;
  localparam int unsigned SUM_FRAC = SQ_FRAC + FRAC_W;
  localparam int unsigned Z_SHIFT  = SUM_FRAC - DAC_W;

  function automatic logic signed [ACC_W-1:0] poly(input logic [COEF_W-1:0] c0,
                                                    input logic [COEF_W-1:0] c1,
                                                    input logic [COEF_W-1:0] c2,
                                                    input logic signed [COEF_W:0] d);
    logic signed [ACC_W-1:0] d_ext;
    logic signed [ACC_W-1:0] sq;
    logic signed [ACC_W-1:0] t0;
    logic signed [ACC_W-1:0] t1;
    logic signed [ACC_W-1:0] t2;
    d_ext = ACC_W'(d);
    sq    = d_ext * d_ext;
    t0    = $signed({{(ACC_W-DAC_W){1'b0}}, c0[DAC_W-1:0]}) <<< Z_SHIFT;
    t1    = (ACC_W'($signed(c1)) * d_ext) <<< FRAC_W;
    t2    = ACC_W'($signed(c2)) * sq;
    poly  = t0 + t1 + t2;
  endfunction : poly

  logic signed [ACC_W-1:0] gain_sum;
  logic signed [ACC_W-1:0] offset_sum;

  assign gain_sum   = poly(gain_coeff_zero, gain_coeff_first, gain_coeff_second, diff);
  assign offset_sum = poly(offset_coeff_zero, offset_coeff_first, offset_coeff_second, diff);

  // Unit value on the accumulator scale
  localparam logic signed [ACC_W-1:0] UNIT = ACC_W'(1) <<< SUM_FRAC;

  // ****************************************
  // Truncation, range check and DAC codes
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fine       <= '0;
      fine_valid <= 1'b0;
    end
    else
    begin
      fine_valid <= calc_go;
      if (calc_go)
      begin
        fine.fine_gain_code   <= gain_sum[SUM_FRAC-1 -: DAC_W];
        fine.fine_offset_code <= offset_sum[SUM_FRAC-1 -: DAC_W];
        fine.gain_fault       <= (gain_sum < 0) || (gain_sum > UNIT);
        fine.offset_fault     <= (offset_sum < 0) || (offset_sum > UNIT);
      end
    end
  end

endmodule : tcc_coeff_engine

// ===== testbench/tcc_checker_sva.sv
`timescale 1ns/100ps
module tcc_checker
  import tcc_pkg::*;
#(parameter int unsigned TEMP_BITS = 10)
(
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  // Memory port
  input wire logic                       cal_wr,
  input wire logic [tcc_pkg::ADDR_W-1:0] cal_addr,
  input wire logic [tcc_pkg::WORD_W:0]   cal_wdata,
  input wire logic [tcc_pkg::WORD_W:0]   cal_rdata,
  input wire logic                       cal_parity_err,
  // Temperature and settings
  input wire logic                       temp_valid,
  input wire logic [TEMP_BITS-1:0]       temp_value,
  input wire tcc_pkg::tcc_coarse_t       coarse,
  input wire tcc_pkg::tcc_fine_t         fine,
  input wire logic                       fine_valid
);
  import tcc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Write, then a quiet cycle on the same word
  sequence wr_hold;
    cal_wr ##1 (!cal_wr && $stable(cal_addr));
  endsequence
  AST_FINE_LAT: assert property (temp_valid |-> ##2 fine_valid) else $error("late result");
  AST_NO_SPUR: assert property (fine_valid |-> $past(temp_valid, 2)) else $error("stray result");
  AST_FINE_HOLD: assert property (!fine_valid |-> $stable(fine)) else $error("fine moved");
  AST_SWAP: assert property (cal_wr && cal_addr == ADDR_CGAIN |-> ##2
    coarse.input_swap == $past(cal_wdata[3], 2)) else $error("swap bit");
  AST_GAIN_SEL: assert property (cal_wr && cal_addr == ADDR_CGAIN |-> ##2
    {coarse.third_stage_gain, coarse.second_stage_gain, coarse.first_stage_amp} == $past(cal_wdata[2:0], 2))
    else $error("gain select");
  AST_COFF_LO: assert property (cal_wr && cal_addr == ADDR_COFF_LO |-> ##2
    coarse.coarse_offset_value[3:0] == $past(cal_wdata[3:0], 2)) else $error("offset low");
  AST_COFF_HI: assert property (cal_wr && cal_addr == ADDR_COFF_HI |-> ##2
    coarse.coarse_offset_value[6:4] == $past(cal_wdata[2:0], 2)) else $error("offset high");
  AST_PARITY: assert property ($past(rst_n) |-> cal_parity_err == ~^cal_rdata) else $error("parity flag");
  AST_READBACK: assert property (wr_hold |=> cal_rdata == $past(cal_wdata, 2)) else $error("readback");
endmodule : tcc_checker

bind tcc_coeff_engine tcc_checker #(.TEMP_BITS(TEMP_BITS)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .cal_wr(cal_wr), .cal_addr(cal_addr), .cal_wdata(cal_wdata), .cal_rdata(cal_rdata),
  .cal_parity_err(cal_parity_err), .temp_valid(temp_valid), .temp_value(temp_value),
  .coarse(coarse), .fine(fine), .fine_valid(fine_valid));

// ===== testbench/tcc_adc_model.sv
`timescale 1ns/100ps
module tcc_adc_model
#(parameter int unsigned BITS = 10)
(
  // Clock
  input wire logic            ref_clk,
  // Conversion request
  input wire logic            go,
  input wire logic [BITS-1:0] code,
  // Result towards the engine
  output logic                temp_valid = 1'b0,
  output logic [BITS-1:0]     temp_value = '0
);
  // One-cycle result pulse; value scrambles between results
  always @(posedge ref_clk)
  begin
    temp_valid <= go;
    temp_value <= go ? code : ~temp_value;
  end
endmodule : tcc_adc_model

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tcc_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cal_wr = 1'b0;
  logic [ADDR_W-1:0] cal_addr = '0;
  logic [WORD_W:0]   cal_wdata = '0;
  logic [WORD_W:0]   cal_rdata;
  logic              cal_parity_err, temp_valid, fine_valid, adc_go = 1'b0;
  logic [9:0]        temp_value, adc_code = '0;
  tcc_coarse_t       coarse;
  tcc_fine_t         fine;
  int                n_mismatch = 0;
  int                checks_done = 0;

  // Clock and parts
  initial forever #5 ref_clk = ~ref_clk;
  tcc_adc_model #(.BITS(10)) adc (.ref_clk(ref_clk), .go(adc_go), .code(adc_code), .temp_valid(temp_valid),
    .temp_value(temp_value));
  tcc_coeff_engine #(.TEMP_BITS(10)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .cal_wr(cal_wr), .cal_addr(cal_addr),
    .cal_wdata(cal_wdata), .cal_rdata(cal_rdata), .cal_parity_err(cal_parity_err), .temp_valid(temp_valid),
    .temp_value(temp_value), .coarse(coarse), .fine(fine), .fine_valid(fine_valid));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // One memory word, parity spoilt on request
  task automatic wr(logic [4:0] a, logic [3:0] d, logic bad = 1'b0);
    @(posedge ref_clk);
    cal_wr <= 1'b1;
    cal_addr <= a;
    cal_wdata <= {~^d ^ bad, d};
    @(posedge ref_clk);
    cal_wr <= 1'b0;
  endtask : wr

  task automatic wr12(logic [4:0] a, logic [11:0] v);
    for (int i = 0; i < 3; i++) wr(5'(a + i), v[4*i +: 4]);
  endtask : wr12

  // Polynomial on a 2^-33 scale, code below the unit bit
  function automatic logic [10:0] expect_fine(logic [11:0] c0, c1, c2, logic [9:0] t);
    longint d, s;
    d = {t, 1'b0} - 11'h400;
    s = (longint'(c0[9:0]) <<< 23) + ((longint'($signed(c1)) * d) <<< 11) + longint'($signed(c2)) * d * d;
    return {(s < 0 || s > (longint'(1) <<< 33)), s[32:23]};
  endfunction : expect_fine

  task automatic coarse_and_parity;
    wr(ADDR_CGAIN, 4'hA);
    wr(ADDR_COFF_LO, 4'h5);
    wr(ADDR_COFF_HI, 4'hE);
    @(posedge ref_clk);
    #1 chk("coarse", 11'h2E5, coarse);
    for (int b = 1; b >= 0; b--)
    begin
      wr(5'h03, 4'h9, 1'(b));
      @(posedge ref_clk);
      #1 chk("rdata", {~1'(b), 4'h9}, cal_rdata);
      chk("perr", 32'(b), cal_parity_err);
    end
  endtask : coarse_and_parity

  task automatic poly_case(logic [11:0] g0, g1, g2, o0, o1, o2, logic [9:0] t);
    int n;
    wr12(ADDR_G0, g0);
    wr12(ADDR_G1, g1);
    wr12(ADDR_G2, g2);
    wr12(ADDR_O0, o0);
    wr12(ADDR_O1, o1);
    wr12(ADDR_O2, o2);
    @(posedge ref_clk);
    adc_go <= 1'b1;
    adc_code <= t;
    @(posedge ref_clk);
    adc_go <= 1'b0;
    for (n = 0; n < 8 && fine_valid !== 1'b1; n++) @(posedge ref_clk) #1;
    chk("done", 1, fine_valid);
    if (n == 8) give_verdict();
    chk("gain", expect_fine(g0, g1, g2, t), {fine.gain_fault, fine.fine_gain_code});
    chk("offs", expect_fine(o0, o1, o2, t), {fine.offset_fault, fine.fine_offset_code});
  endtask : poly_case

  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    coarse_and_parity();
    wr12(ADDR_ROOM_REF, 12'h400);
    poly_case(12'h200, 12'h100, 12'h080, 12'h100, 12'hF00, 12'hFC0, 10'h280);
    poly_case(12'h000, 12'h400, 12'h000, 12'h3FF, 12'h7FF, 12'h7FF, 10'h100);
    poly_case(12'h3FF, 12'h000, 12'h000, 12'h3FF, 12'h7FF, 12'h000, 10'h3FF);
    give_verdict();
  end
endmodule : testbench
